// ===== amcs_sequencer.sv
// Summary of operation
// - fields give turnaround 1-4, setup 1-16, strobe 1-64, hold 1-8, timeout 1-256
// - a turnaround phase of the programmed length precedes every read and write
// - unextended read lasts setup plus strobe plus hold periods
// - extended read grows by sixteen periods per counted wait cycle
// - chip select leads read strobe by setup, trails it by hold
// - in select strobe mode chip select moves with output enable
// - read address, bank, byte masks valid setup before and hold after strobe
// - output enable low for read strobe plus sixteen per wait cycle
// - extended read strobe rises about four periods after wait releases
// - unextended write lasts setup plus strobe plus hold periods
// - extended write grows by sixteen periods per counted wait cycle
// - chip select leads and trails write enable, or coincides in strobe mode
// - write address, bank, masks, data valid setup before and hold after strobe
// - write enable low for write strobe plus sixteen per wait cycle
// - extended write strobe rises about four periods after wait releases
// - wait cycles counted up to 256, waiting stops at the timeout limit
`include "amcs_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module amcs_fifo #(
   parameter int WIDTH = 45,
   parameter int DEPTH = `AMCS_FIFO_DEPTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [AW:0] fill, next_fill;
   logic push, pop;

   // depth is a power of two, so the pointers wrap by themselves
   always_comb begin
      push = inValid && inReady;
      pop = outValid && outReady;
      next_wrPtr = wrPtr + AW'(push);
      next_rdPtr = rdPtr + AW'(pop);
      next_fill = fill + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         fill <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         fill <= next_fill;
      end
   end

   // storage needs no reset, reads are gated by fill
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   assign inReady = fill != (AW+1)'(DEPTH);
   assign outValid = fill != '0;
   assign outData = mem[rdPtr];
endmodule

////////////////////////////////////////////////////////////////////////////////
module amcs_sequencer (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // access requests
   input wire logic reqValid,
   output logic reqReady,
   input wire amcs_pkg::amcs_req_t reqWord,
   // configuration
   input wire amcs_pkg::amcs_cfg_t cfg,
   // status
   output logic timeoutFlag,
   input wire logic timeoutClear,
   output logic busy,
   // responses
   output logic rdValid,
   output logic [15:0] rdData,
   output logic doneValid,
   // memory pins
   output logic [2:0] memChipSelectN,
   output logic memOutputEnableN,
   output logic memWriteEnableN,
   input wire logic memWaitN,
   output logic [1:0] memBankSelect,
   output logic [21:0] memAddress,
   input wire logic [15:0] memDataIn,
   output logic [15:0] memDataOut,
   output logic memDataOe,
   output logic [1:0] memByteMaskN
);
   amcs_pkg::amcs_state_t state, next_state;
   amcs_pkg::amcs_req_t cur, next_cur, fifoWord;
   logic [7:0] cnt, next_cnt;
   logic [3:0] unit, next_unit;
   logic [8:0] wait_extension_count, next_ewc;
   logic waitSeen, next_waitSeen, waitSync1, waitSync2;
   logic next_timeoutFlag, next_rdValid, next_doneValid;
   logic [15:0] next_rdData;
   logic [2:0] next_memChipSelectN;
   logic next_memOutputEnableN, next_memWriteEnableN, next_memDataOe;
   logic fifoValid, fifoPop, endStrobe, tmoEvent, waitOn, active, strobe;

   // queue in front of the sequencer; a full queue stalls the requester
   amcs_fifo #(.WIDTH($bits(amcs_pkg::amcs_req_t)), .DEPTH(`AMCS_FIFO_DEPTH)) reqQueue (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .inValid(reqValid),
      .inReady(reqReady),
      .inData(reqWord),
      .outValid(fifoValid),
      .outReady(fifoPop),
      .outData(fifoWord)
   );

   // phase length minus one; fields already hold count minus one
   function automatic logic [7:0] phaseLoad(amcs_pkg::amcs_state_t s, logic wr,
                                            amcs_pkg::amcs_cfg_t c);
      logic [7:0] v;
      v = 8'h00;
      case (s)
         amcs_pkg::ST_TURN: v = 8'(c.busTurnaroundCycles);
         amcs_pkg::ST_SETUP: v = wr ? 8'(c.writeSetupCycles) : 8'(c.readSetupCycles);
         amcs_pkg::ST_STROBE: v = wr ? 8'(c.writeStrobeCycles) : 8'(c.readStrobeCycles);
         amcs_pkg::ST_HOLD: v = wr ? 8'(c.writeHoldCycles) : 8'(c.readHoldCycles);
         amcs_pkg::ST_TAIL: v = 8'(`AMCS_TAIL_CYC - 1);
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // wait pin is active low and only the second stage is looked at
   assign waitOn = cfg.extendedWaitEnable && !waitSync2;

   ////////////////////////////////////////////////////////////////////////////
   // cycle sequencing
   always_comb begin
      next_state = state;
      next_cur = cur;
      next_cnt = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
      next_unit = unit;
      next_ewc = wait_extension_count;
      next_waitSeen = waitSeen;
      fifoPop = 1'b0;
      endStrobe = 1'b0;
      tmoEvent = 1'b0;
      next_doneValid = 1'b0;
      case (state)
         amcs_pkg::ST_IDLE: begin
            if (fifoValid) begin
               fifoPop = 1'b1;
               next_cur = fifoWord;
               next_state = amcs_pkg::ST_TURN;
               next_cnt = phaseLoad(amcs_pkg::ST_TURN, fifoWord.write, cfg);
            end
         end
         amcs_pkg::ST_TURN: begin
            if (cnt == 8'h00) begin
               next_state = amcs_pkg::ST_SETUP;
               next_cnt = phaseLoad(amcs_pkg::ST_SETUP, cur.write, cfg);
            end
         end
         amcs_pkg::ST_SETUP: begin
            next_waitSeen = 1'b0;
            if (cnt == 8'h00) begin
               next_state = amcs_pkg::ST_STROBE;
               next_cnt = phaseLoad(amcs_pkg::ST_STROBE, cur.write, cfg);
            end
         end
         amcs_pkg::ST_STROBE: begin
            if (waitOn) begin
               next_waitSeen = 1'b1;
            end
            if (cnt == 8'h00) begin
               // wait must be seen before the strobe would end
               if (waitSeen || waitOn) begin
                  next_state = amcs_pkg::ST_EXTEND;
                  next_unit = 4'h0;
                  next_ewc = 9'h000;
               end else begin
                  endStrobe = 1'b1;
               end
            end
         end
         amcs_pkg::ST_EXTEND: begin
            // stretch in granules of sixteen periods
            next_unit = unit + 4'h1;
            if (unit == 4'(`AMCS_WAIT_UNIT_CYC - 1)) begin
               next_ewc = wait_extension_count + 9'h001;
            end
            if (!waitOn) begin
               next_state = amcs_pkg::ST_TAIL;
               next_cnt = phaseLoad(amcs_pkg::ST_TAIL, cur.write, cfg);
            end else if (unit == 4'(`AMCS_WAIT_UNIT_CYC - 1)
                         && wait_extension_count + 9'h001 == {1'b0, cfg.waitTimeoutLimit} + 9'h001) begin
               tmoEvent = 1'b1;
               endStrobe = 1'b1;
            end
         end
         amcs_pkg::ST_TAIL: begin
            if (cnt == 8'h00) begin
               endStrobe = 1'b1;
            end
         end
         amcs_pkg::ST_HOLD: begin
            if (cnt == 8'h00) begin
               next_state = amcs_pkg::ST_IDLE;
               next_doneValid = 1'b1;
            end
         end
         default: begin
            next_state = amcs_pkg::ST_IDLE;
         end
      endcase
      // strobe phase over: hold phase runs normally even after a timeout
      if (endStrobe) begin
         next_state = amcs_pkg::ST_HOLD;
         next_cnt = phaseLoad(amcs_pkg::ST_HOLD, cur.write, cfg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // results, status and pin values, taken from the next state
   always_comb begin
      // read data is sampled in the last cycle with output enable low
      next_rdValid = endStrobe && !cur.write;
      next_rdData = next_rdValid ? memDataIn : rdData;
      // a new timeout wins over a clear in the same cycle
      next_timeoutFlag = (timeoutFlag && !timeoutClear) || tmoEvent;
      active = next_state inside {amcs_pkg::ST_SETUP, amcs_pkg::ST_STROBE,
                                  amcs_pkg::ST_EXTEND, amcs_pkg::ST_TAIL,
                                  amcs_pkg::ST_HOLD};
      strobe = next_state inside {amcs_pkg::ST_STROBE, amcs_pkg::ST_EXTEND,
                                  amcs_pkg::ST_TAIL};
      next_memOutputEnableN = !(strobe && !next_cur.write);
      next_memWriteEnableN = !(strobe && next_cur.write);
      // select strobe mode narrows the select to the strobe window
      if (cfg.selectStrobe ? strobe : active) begin
         next_memChipSelectN = ~(3'h1 << next_cur.chipSel);
      end else begin
         next_memChipSelectN = `AMCS_CS_IDLE;
      end
      next_memDataOe = active && next_cur.write;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state <= amcs_pkg::ST_IDLE;
         cur <= '0;
         cnt <= 8'h00;
         unit <= 4'h0;
         wait_extension_count <= 9'h000;
         waitSeen <= 1'b0;
         waitSync1 <= 1'b1;
         waitSync2 <= 1'b1;
         timeoutFlag <= 1'b0;
         rdValid <= 1'b0;
         rdData <= 16'h0000;
         doneValid <= 1'b0;
         memChipSelectN <= `AMCS_CS_IDLE;
         memOutputEnableN <= 1'b1;
         memWriteEnableN <= 1'b1;
         memDataOe <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         cnt <= next_cnt;
         unit <= next_unit;
         wait_extension_count <= next_ewc;
         waitSeen <= next_waitSeen;
         waitSync1 <= memWaitN;
         waitSync2 <= waitSync1;
         timeoutFlag <= next_timeoutFlag;
         rdValid <= next_rdValid;
         rdData <= next_rdData;
         doneValid <= next_doneValid;
         memChipSelectN <= next_memChipSelectN;
         memOutputEnableN <= next_memOutputEnableN;
         memWriteEnableN <= next_memWriteEnableN;
         memDataOe <= next_memDataOe;
      end
   end

   // address side follows the held request for the whole cycle
   assign memAddress = cur.address;
   assign memBankSelect = cur.bank;
   assign memByteMaskN = (state == amcs_pkg::ST_IDLE) ? `AMCS_MASK_IDLE : cur.byteMaskN;
   assign memDataOut = cur.data;
   assign busy = state != amcs_pkg::ST_IDLE;

   ////////////////////////////////////////////////////////////////////////////
   // checking helpers: cycle counts seen at the pins
   logic [11:0] cycCnt, strCnt;
   logic [2:0] turnCnt;
   logic extSeen;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cycCnt <= 12'h000;
         strCnt <= 12'h000;
         turnCnt <= 3'h0;
         extSeen <= 1'b0;
      end else begin
         cycCnt <= (state inside {amcs_pkg::ST_IDLE, amcs_pkg::ST_TURN}) ? 12'h000
                   : cycCnt + 12'h001;
         strCnt <= (!memOutputEnableN || !memWriteEnableN) ? strCnt + 12'h001 : 12'h000;
         turnCnt <= (state == amcs_pkg::ST_TURN) ? turnCnt + 3'h1 : 3'h0;
         extSeen <= (state == amcs_pkg::ST_IDLE) ? 1'b0
                    : (extSeen || state == amcs_pkg::ST_EXTEND);
      end
   end

   sequence s_readOpen;
      $fell(memOutputEnableN);
   endsequence
   sequence s_writeOpen;
      $fell(memWriteEnableN);
   endsequence

   property p_turnLen;
      @(posedge ref_clk) disable iff (!rstn)
      (state == amcs_pkg::ST_TURN && next_state == amcs_pkg::ST_SETUP)
      |-> turnCnt == 3'(cfg.busTurnaroundCycles);
   endproperty
   a_turnLen: assert property (p_turnLen) else $error("turnaround length wrong");

   property p_readLead;
      @(posedge ref_clk) disable iff (!rstn)
      s_readOpen |-> cycCnt == 12'(cfg.readSetupCycles) + 12'h001 && memChipSelectN != 3'h7;
   endproperty
   a_readLead: assert property (p_readLead) else $error("read setup lead wrong");

   property p_writeLead;
      @(posedge ref_clk) disable iff (!rstn)
      s_writeOpen |-> cycCnt == 12'(cfg.writeSetupCycles) + 12'h001 && memDataOe;
   endproperty
   a_writeLead: assert property (p_writeLead) else $error("write setup lead wrong");

   property p_oeWidth;
      @(posedge ref_clk) disable iff (!rstn)
      $rose(memOutputEnableN) && !extSeen
      |-> $past(strCnt) == 12'(cfg.readStrobeCycles);
   endproperty
   a_oeWidth: assert property (p_oeWidth) else $error("read strobe width wrong");

   property p_weWidth;
      @(posedge ref_clk) disable iff (!rstn)
      $rose(memWriteEnableN) && !extSeen
      |-> $past(strCnt) == 12'(cfg.writeStrobeCycles);
   endproperty
   a_weWidth: assert property (p_weWidth) else $error("write strobe width wrong");

   property p_cycleLen;
      @(posedge ref_clk) disable iff (!rstn)
      next_doneValid && !extSeen |-> cycCnt + 12'h001 == (cur.write
         ? 12'(cfg.writeSetupCycles) + 12'(cfg.writeStrobeCycles)
           + 12'(cfg.writeHoldCycles) + 12'h003
         : 12'(cfg.readSetupCycles) + 12'(cfg.readStrobeCycles)
           + 12'(cfg.readHoldCycles) + 12'h003);
   endproperty
   a_cycleLen: assert property (p_cycleLen) else $error("cycle length wrong");

   property p_selStrobe;
      @(posedge ref_clk) disable iff (!rstn)
      cfg.selectStrobe && $stable(cfg.selectStrobe) && state != amcs_pkg::ST_TURN
      |=> (memChipSelectN == 3'h7) == (memOutputEnableN && memWriteEnableN);
   endproperty
   a_selStrobe: assert property (p_selStrobe) else $error("select not with strobe");

   property p_release;
      @(posedge ref_clk) disable iff (!rstn)
      state == amcs_pkg::ST_EXTEND && next_state == amcs_pkg::ST_TAIL
      |-> ##[2:3] ($rose(memOutputEnableN) || $rose(memWriteEnableN));
   endproperty
   a_release: assert property (p_release) else $error("strobe release late");

   property p_timeout;
      @(posedge ref_clk) disable iff (!rstn)
      tmoEvent |=> timeoutFlag && state == amcs_pkg::ST_HOLD
                   && wait_extension_count == {1'b0, cfg.waitTimeoutLimit} + 9'h001;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout not taken");

   property p_addrStable;
      @(posedge ref_clk) disable iff (!rstn)
      busy && state != amcs_pkg::ST_TURN |=> $stable(memAddress) || !busy;
   endproperty
   a_addrStable: assert property (p_addrStable) else $error("address moved");

   property p_sync;
      @(posedge ref_clk) disable iff (!rstn)
      !$past(memWaitN, 2) && !$past(memWaitN) |-> !waitSync2;
   endproperty
   a_sync: assert property (p_sync) else $error("wait sync depth wrong");
endmodule

// ===== amcs_defines.svh
`ifndef AMCS_DEFINES_SVH
`define AMCS_DEFINES_SVH
// interface clock period in ns (50 MHz)
`define AMCS_CLK_PERIOD_NS 20
// wait extension granule, in interface clock periods
`define AMCS_WAIT_UNIT_CYC 16
// strobe release after wait deassertion, in interface clock periods
`define AMCS_WAIT_RELEASE_CYC 4
// synchroniser depth on the wait input
`define AMCS_SYNC_STAGES 2
// tail cycles left once the synchroniser delay is taken off
`define AMCS_TAIL_CYC (`AMCS_WAIT_RELEASE_CYC - `AMCS_SYNC_STAGES)
// request queue depth
`define AMCS_FIFO_DEPTH 32
// reset values of the memory pins
`define AMCS_CS_IDLE 3'h7
`define AMCS_MASK_IDLE 2'h3
`endif

// ===== amcs_pkg.sv
package amcs_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_TURN = 3'b001,
      ST_SETUP = 3'b010,
      ST_STROBE = 3'b011,
      ST_EXTEND = 3'b100,
      ST_TAIL = 3'b101,
      ST_HOLD = 3'b110
   } amcs_state_t;
   // one queued access
   typedef struct packed {
      logic write;
      logic [1:0] chipSel;
      logic [1:0] bank;
      logic [21:0] address;
      logic [15:0] data;
      logic [1:0] byteMaskN;
   } amcs_req_t;
   // every cycle field holds its count minus one
   typedef struct packed {
      logic [1:0] busTurnaroundCycles;
      logic [3:0] readSetupCycles;
      logic [5:0] readStrobeCycles;
      logic [2:0] readHoldCycles;
      logic [3:0] writeSetupCycles;
      logic [5:0] writeStrobeCycles;
      logic [2:0] writeHoldCycles;
      logic [7:0] waitTimeoutLimit;
      logic extendedWaitEnable;
      logic selectStrobe;
   } amcs_cfg_t;
endpackage

// ===== amcs_mem_model.sv
// asynchronous memory part on the far side of the sequencer
module amcs_mem_model (
   // clock
   input wire logic ref_clk,
   // memory pins from the sequencer
   input wire logic [2:0] memChipSelectN,
   input wire logic memOutputEnableN,
   input wire logic memWriteEnableN,
   input wire logic [21:0] memAddress,
   input wire logic [1:0] memByteMaskN,
   input wire logic [15:0] memDataOut,
   input wire logic memDataOe,
   output logic [15:0] memDataIn,
   output logic memWaitN,
   // wait length commanded by the bench, 0 for none
   input wire logic [31:0] waitCycles
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:255];
   logic [15:0] lastData = 16'h0000;
   logic stbPrev = 1'b0;
   int waitLeft = 0;
   wire selected = (memChipSelectN != 3'h7);
   wire strobe = !memOutputEnableN || !memWriteEnableN;

   ////////////////////////////////////////////////////////////////////////////
   // store enabled lanes while write strobe is low; masked lanes keep contents
   always @(posedge ref_clk) begin
      if (selected && !memWriteEnableN && memDataOe) begin
         if (!memByteMaskN[0]) mem[memAddress[7:0]][7:0] <= memDataOut[7:0];
         if (!memByteMaskN[1]) mem[memAddress[7:0]][15:8] <= memDataOut[15:8];
      end
      if (selected && !memOutputEnableN) lastData <= mem[memAddress[7:0]];
   end

   // released bus shows the inverse of the last value, never a stale match
   always @* begin
      if (selected && !memOutputEnableN) memDataIn = mem[memAddress[7:0]];
      else memDataIn = ~lastData;
   end

   ////////////////////////////////////////////////////////////////////////////
   // wait from the second strobe cycle, well ahead of the unextended hold
   always @(posedge ref_clk) begin
      if (strobe && !stbPrev && waitCycles > 0) waitLeft <= waitCycles;
      else if (waitLeft > 0) waitLeft <= waitLeft - 1;
      stbPrev <= strobe;
   end
   assign memWaitN = (waitLeft == 0);
endmodule

// ===== amcs_sequencer_tb_top.sv
`include "amcs_defines.svh"
module amcs_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk, rstn, reqValid, reqReady, timeoutFlag, timeoutClear, busy;
   logic rdValid, doneValid, memOutputEnableN, memWriteEnableN, memWaitN, memDataOe;
   logic [15:0] rdData, memDataIn, memDataOut, rdSeen;
   logic [2:0] memChipSelectN;
   logic [1:0] memBankSelect, memByteMaskN;
   logic [21:0] memAddress;
   amcs_pkg::amcs_req_t reqWord, expReq;
   amcs_pkg::amcs_cfg_t cfg;
   int waitCycles, mismatches, samples_checked, curT, curSs, curCs;
   int busyCnt, preCnt, setupCnt, stbCnt, holdCnt, csHoldCnt, doneCnt, tick, relT, riseT;
   logic lastWait, lastStb, refusedSeen;
   int tabT[3] = '{1, 4, 2};
   int tabRS[3] = '{1, 16, 3};
   int tabRP[3] = '{1, 5, 4};
   int tabRH[3] = '{1, 8, 2};
   int tabWS[3] = '{2, 16, 1};
   int tabWP[3] = '{3, 1, 6};
   int tabWH[3] = '{4, 8, 1};
   int tabSs[3] = '{0, 0, 1};

   amcs_sequencer u_amcs_sequencer (.ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid),
      .reqReady(reqReady), .reqWord(reqWord), .cfg(cfg), .timeoutFlag(timeoutFlag),
      .timeoutClear(timeoutClear), .busy(busy), .rdValid(rdValid), .rdData(rdData),
      .doneValid(doneValid), .memChipSelectN(memChipSelectN),
      .memOutputEnableN(memOutputEnableN), .memWriteEnableN(memWriteEnableN),
      .memWaitN(memWaitN), .memBankSelect(memBankSelect), .memAddress(memAddress),
      .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe(memDataOe),
      .memByteMaskN(memByteMaskN));
   amcs_mem_model u_amcs_mem_model (.ref_clk(ref_clk), .memChipSelectN(memChipSelectN),
      .memOutputEnableN(memOutputEnableN), .memWriteEnableN(memWriteEnableN),
      .memAddress(memAddress), .memByteMaskN(memByteMaskN), .memDataOut(memDataOut),
      .memDataOe(memDataOe), .memDataIn(memDataIn), .memWaitN(memWaitN),
      .waitCycles(waitCycles));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // pin monitor: samples each finished cycle on the rising edge, no race
   always @(posedge ref_clk) begin
      if (rstn) begin
         automatic logic stb = !memOutputEnableN || !memWriteEnableN;
         automatic logic csLow = memChipSelectN != `AMCS_CS_IDLE;
         if (busy) busyCnt++;
         if (busy && !stb && stbCnt == 0) begin
            if (csLow) setupCnt++;
            else preCnt++;
         end
         if (busy && !stb && stbCnt > 0) begin
            holdCnt++;
            if (csLow) csHoldCnt++;
         end
         if (stb) stbCnt++;
         tick++;
         if (memWaitN && !lastWait) relT = tick;
         if (lastStb && !stb) riseT = tick;
         lastWait = memWaitN;
         lastStb = stb;
         if (doneValid) doneCnt++;
         if (rdValid) rdSeen = rdData;
         if (!reqReady) refusedSeen = 1'b1;
         // everything the part latches must stand while it is selected
         if (csLow) begin
            chk("chip select", 32'(memChipSelectN), 32'(3'(~(3'h1 << expReq.chipSel))));
            chk("address", 32'(memAddress), 32'(expReq.address));
            chk("bank", 32'(memBankSelect), 32'(expReq.bank));
            chk("byte mask", 32'(memByteMaskN), 32'(expReq.byteMaskN));
            chk("data drive", 32'(memDataOe), 32'(expReq.write));
            if (expReq.write) chk("write data", 32'(memDataOut), 32'(expReq.data));
         end
      end
   end

   task automatic set_cfg(input int t, rs, rp, rh, ws, wp, wh, ss, ew, lim);
      cfg = {2'(t - 1), 4'(rs - 1), 6'(rp - 1), 3'(rh - 1), 4'(ws - 1), 6'(wp - 1),
         3'(wh - 1), 8'(lim - 1), 1'(ew), 1'(ss)};
      curT = t;
      curSs = ss;
   endtask

   // hold the offer until a rising edge sees the queue ready
   task automatic push(input amcs_pkg::amcs_req_t w);
      int n;
      n = 0;
      reqValid = 1'b1;
      reqWord = w;
      while (!reqReady && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      // a queue that never frees up counts against the run
      if (n >= 300) mismatches++;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   // one access on an idle sequencer; strobe width check skipped and cycle check loosened when extended
   task automatic access(input logic wr, input logic [15:0] d, input logic [1:0] m,
         input int s, p, h, input bit ext);
      int n;
      expReq = {wr, 2'(curCs), 2'(curCs + 1), 22'h2a_5000 + 22'(curCs), d, m};
      {busyCnt, preCnt, setupCnt, stbCnt, holdCnt, csHoldCnt, doneCnt} = '0;
      push(expReq);
      reqValid = 1'b0;
      n = 0;
      while (doneCnt == 0 && n < 3000) begin
         @(negedge ref_clk);
         n++;
      end
      chk("done", 32'(doneCnt), 32'd1);
      chk("turnaround", 32'(preCnt), 32'(curSs ? curT + s : curT));
      chk("select lead", 32'(setupCnt), 32'(curSs ? 0 : s));
      chk("select trail", 32'(csHoldCnt), 32'(curSs ? 0 : h));
      chk("hold", 32'(holdCnt), 32'(h));
      if (!ext) begin
         chk("strobe width", 32'(stbCnt), 32'(p));
         chk("cycle", 32'(busyCnt - curT), 32'(s + p + h));
      end
      else chk("extended cycle", 32'(busyCnt - curT), 32'(s + stbCnt + h));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rstn, reqValid, timeoutClear, reqWord, cfg, expReq} = '0;
      {waitCycles, mismatches, samples_checked, tick, relT, riseT, curCs} = '0;
      // wait pin idles high, so no false release edge after reset
      {lastWait, lastStb, refusedSeen} = 3'h4;
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      chk("idle select", 32'(memChipSelectN), 32'(`AMCS_CS_IDLE));
      chk("idle strobes", 32'({memOutputEnableN, memWriteEnableN}), 32'd3);
      chk("idle ready", 32'(reqReady), 32'd1);
      // cycle field table, bounds of each range except the strobe maximum, both select modes
      for (int i = 0; i < 3; i++) begin
         set_cfg(tabT[i], tabRS[i], tabRP[i], tabRH[i], tabWS[i], tabWP[i], tabWH[i],
            tabSs[i], 0, 1);
         curCs = i;
         access(1'b1, 16'h5a00 + 16'(i), 2'h0, tabWS[i], tabWP[i], tabWH[i], 0);
         access(1'b0, 16'h0000, 2'h0, tabRS[i], tabRP[i], tabRH[i], 0);
         chk("read data", 32'(rdSeen), 32'h5a00 + 32'(i));
      end
      // upper lane masked off keeps its old byte
      access(1'b1, 16'hab_cd, 2'h2, tabWS[2], tabWP[2], tabWH[2], 0);
      access(1'b0, 16'h0000, 2'h0, tabRS[2], tabRP[2], tabRH[2], 0);
      chk("masked write", 32'(rdSeen), 32'h5acd);
      // wait extension under the largest timeout limit
      set_cfg(2, 2, 8, 2, 3, 8, 3, 0, 1, 256);
      waitCycles = 40;
      // write first, so the extended read returns what was just stored
      for (int i = 0; i < 2; i++) begin
         access(1'(1 - i), 16'h3c3c, 2'h0, 3 - i, 8, 3 - i, 1);
         chk("strobe extended", 32'(stbCnt > 8 + 30), 32'd1);
         chk("wait release", 32'(riseT - relT >= 3 && riseT - relT <= 5), 32'd1);
      end
      chk("read after extension", 32'(rdSeen), 32'h3c3c);
      chk("no timeout", 32'(timeoutFlag), 32'd0);
      // a wait longer than one granule limit times out and stays flagged
      set_cfg(2, 2, 8, 2, 3, 8, 3, 0, 1, 1);
      waitCycles = 100;
      access(1'b0, 16'h0000, 2'h0, 2, 8, 2, 1);
      chk("timeout strobe", 32'(stbCnt >= 8 + 16 && stbCnt <= 8 + 24), 32'd1);
      waitCycles = 0;
      repeat (100) @(negedge ref_clk);
      chk("timeout flag", 32'(timeoutFlag), 32'd1);
      timeoutClear = 1'b1;
      @(negedge ref_clk);
      timeoutClear = 1'b0;
      chk("timeout cleared", 32'(timeoutFlag), 32'd0);
      // longest strobe keeps the queue filling until it refuses, then drains
      set_cfg(1, 1, 64, 1, 1, 64, 1, 0, 0, 1);
      curCs = 3;
      expReq = {1'b1, 2'h3, 2'h0, 22'h0, 16'h0, 2'h0};
      {doneCnt, refusedSeen} = '0;
      for (int k = 0; k < `AMCS_FIFO_DEPTH + 2; k++) push(expReq);
      reqValid = 1'b0;
      for (int n = 0; n < 6000 && doneCnt < `AMCS_FIFO_DEPTH + 2; n++) @(negedge ref_clk);
      chk("queue refused", 32'(refusedSeen), 32'd1);
      chk("queue drained", 32'(doneCnt), 32'(`AMCS_FIFO_DEPTH + 2));
      chk("ready again", 32'(reqReady), 32'd1);
      test_done();
   end

   // cut a hang short well beyond the expected run length
   initial begin
      #400000;
      mismatches++;
      test_done();
   end
endmodule
